// ### shared/pstx_pkg.sv
// package: register map, field layout and encoder constants for the power and s/pdif tx block
// Summary of operation
// - power register two resets to zero; bit 9 powers the pll.
// - bit 3 powers right headphone dac, bit 2 left; one is up.
// - bit 1 powers right headphone amp, bit 0 left; one is up.
// - digital power bit 7 powers all pwm channels; default zero.
// - digital power bit 6 powers the s/pdif transmitter; default zero.
// - bit 4 powers rate converter two, bit 3 converter one, bit 0 processor.
// - digital power bit 1 powers the adc/dac engine; default zero.
// - tx control resets to zero; source 000b sends the internal stream.
// - other source codes pass inputs 2,1,0,3,4,5,6 straight through.
// - tx control bit 11 high stops the transmitter, low lets it run.
// - bit 10 picks preamble edge: zero rising, one falling.
// - bit 9 is sent validity flag: zero valid, one invalid.
// - bit 8 is copy indication: zero copyrighted, one not copyrighted.
// - bits 7:0 equipment byte apply only with the internal stream.
`default_nettype none
package pstx_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  POWER_TWO_IDX     = 8'h06;
  localparam logic [7:0]  DIGITAL_POWER_IDX = 8'h07;
  localparam logic [7:0]  TX_CTRL_IDX       = 8'h09;
  localparam logic [15:0] POWER_TWO_RESET   = 16'h0000;
  localparam logic [15:0] DIGITAL_RESET     = 16'h0000;
  localparam logic [15:0] TX_CTRL_RESET     = 16'h0000;
  // writable bits; reserved bits are kept at zero and read as zero
  localparam logic [15:0] POWER_TWO_MASK    = 16'h020F;
  localparam logic [15:0] DIGITAL_MASK      = 16'h00DB;
  localparam logic [15:0] TX_CTRL_MASK      = 16'h7FFF;
  // power register two fields
  localparam int PLL_BIT       = 9;
  localparam int HP_DAC_R_BIT  = 3;
  localparam int HP_DAC_L_BIT  = 2;
  localparam int HP_AMP_R_BIT  = 1;
  localparam int HP_AMP_L_BIT  = 0;
  // digital power fields
  localparam int PWM_BIT       = 7;
  localparam int TX_POWER_BIT  = 6;
  localparam int RC_TWO_BIT    = 4;
  localparam int RC_ONE_BIT    = 3;
  localparam int ENGINE_BIT    = 1;
  localparam int CORE_BIT      = 0;
  // tx control fields
  localparam int SRC_MSB       = 14;
  localparam int SRC_LSB       = 12;
  localparam int TX_DIS_BIT    = 11;
  localparam int PRE_EDGE_BIT  = 10;
  localparam int VALIDITY_BIT  = 9;
  localparam int COPY_BIT      = 8;
  localparam int EQUIP_MSB     = 7;
  localparam int EQUIP_LSB     = 0;
  localparam logic [2:0] SRC_INTERNAL = 3'h0;
  // encoder framing
  localparam int SAMPLE_W          = 24;
  localparam int FIFO_DEPTH        = 2;
  localparam logic [7:0] HALF_CELL_CYCLES = 8'h02;
  localparam logic [5:0] LAST_HALF        = 6'h3F;
  localparam logic [7:0] LAST_FRAME       = 8'hBF;
  localparam logic [7:0] PRE_BLOCK  = 8'hE8;
  localparam logic [7:0] PRE_FIRST  = 8'hE2;
  localparam logic [7:0] PRE_SECOND = 8'hE4;
  localparam logic [4:0] FIRST_DATA_SLOT = 5'h04;
  localparam int AUDIO_LSB_SLOT = 4;
  localparam int VALID_SLOT     = 28;
  localparam int USER_SLOT      = 29;
  localparam int STATUS_SLOT    = 30;
  localparam int PARITY_SLOT    = 31;
  localparam logic [7:0] CS_COPY_FRAME  = 8'h02;
  localparam logic [7:0] CS_EQUIP_FRAME = 8'h08;
  typedef enum logic [1:0] {
    ENC_IDLE = 2'b00,
    ENC_RUN  = 2'b01
  } pstx_enc_state_t;
endpackage
`default_nettype wire

// ### verification/pstx_asserts.sv
// port assertions for the power and s/pdif transmitter block
`default_nettype none
module pstx_asserts
  import pstx_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        pll_power_o,
  input wire logic        headphone_amp_left_power_o,
  input wire logic        spdif_tx_power_o,
  input wire logic        core_power_o,
  input wire logic        sample_ready_o,
  input wire logic        spdif_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_pll_write: assert property ($rose(wb_ack_o) && $past(wb_we_i) && $past(wb_adr_i) == 8'h18
    && $past(wb_sel_i[1]) |-> pll_power_o == $past(wb_dat_i[9]))
    else $error("pll enable not written");
  a_amp_write: assert property ($rose(wb_ack_o) && $past(wb_we_i) && $past(wb_adr_i) == 8'h18
    && $past(wb_sel_i[0]) |-> headphone_amp_left_power_o == $past(wb_dat_i[0]))
    else $error("amp enable not written");
  a_core_write: assert property ($rose(wb_ack_o) && $past(wb_we_i) && $past(wb_adr_i) == 8'h1C
    && $past(wb_sel_i[0]) |-> core_power_o == $past(wb_dat_i[0]))
    else $error("core enable not written");
  a_txpow_write: assert property ($rose(wb_ack_o) && $past(wb_we_i) && $past(wb_adr_i) == 8'h1C
    && $past(wb_sel_i[0]) |-> spdif_tx_power_o == $past(wb_dat_i[6]))
    else $error("tx power not written");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_reset_clear: assert property ($fell(rst_i) |-> !pll_power_o && !core_power_o
    && !spdif_tx_power_o && !wb_ack_o && sample_ready_o)
    else $error("state not cleared by reset");
  a_off_low: assert property (!spdif_tx_power_o [*3] |-> !spdif_o)
    else $error("line active while powered down");
endmodule // pstx_asserts
bind pstx_top pstx_asserts i_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pll_power_o,
  .headphone_amp_left_power_o, .spdif_tx_power_o, .core_power_o, .sample_ready_o, .spdif_o);
`default_nettype wire

// ### verification/pstx_rx_model.sv
// receiver stand-in: counts transitions seen on the line
`default_nettype none
module pstx_rx_model (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   line_i,
  output logic [15:0] edge_cnt_o
);
  logic last_reg;
  always_ff @(posedge clk_i) begin
    last_reg <= line_i;
    if (rst_i) begin
      edge_cnt_o <= 16'h0000;
    end else if (line_i !== last_reg) begin
      edge_cnt_o <= edge_cnt_o + 16'h0001;
    end
  end
endmodule // pstx_rx_model
`default_nettype wire

// ### verification/tb_power_and_spdif_tx_control.sv
// self-checking bench: registers, pass-through mux, encoder flags, sample buffer
`default_nettype none
module tb_power_and_spdif_tx_control;
  import pstx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, sv = 1'b0, sr, line;
  logic ce = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h0, dr;
  logic [10:0] pw;
  logic [23:0] sd = 24'h0;
  logic [6:0] pin = 7'h00;
  logic [15:0] edges, lfsr = 16'h9059, d, e0;
  logic [2303:0] base, cap;
  logic [31:0] exp_q[$];
  int error_cnt = 0, samples_checked = 0, n;
  int map[8] = '{0, 2, 1, 0, 3, 4, 5, 6};
  always #20 clk_i = ~clk_i;
  pstx_top i_dut (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .pll_power_o(pw[10]), .headphone_dac_right_power_o(pw[9]), .headphone_dac_left_power_o(pw[8]),
    .headphone_amp_right_power_o(pw[7]), .headphone_amp_left_power_o(pw[6]),
    .pwm_power_o(pw[5]), .spdif_tx_power_o(pw[4]), .rate_converter_two_power_o(pw[3]),
    .rate_converter_one_power_o(pw[2]), .engine_power_o(pw[1]), .core_power_o(pw[0]),
    .sample_data_i(sd), .sample_valid_i(sv), .sample_ready_o(sr),
    .passthru_input_0_i(pin[0]), .passthru_input_1_i(pin[1]), .passthru_input_2_i(pin[2]),
    .passthru_input_3_i(pin[3]), .passthru_input_4_i(pin[4]), .passthru_input_5_i(pin[5]),
    .passthru_input_6_i(pin[6]), .spdif_o(line));
  pstx_rx_model i_rx (.clk_i, .rst_i, .line_i(line), .edge_cnt_o(edges));
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one classic cycle; request held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= v; sel <= s;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin error_cnt++; wrap_up(); end
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) check(dr, exp_q.pop_front());
  end
  // restart the encoder from cleared counters and record the line
  task automatic capture(input logic [15:0] c);
    wb(1'b1, 8'h24, 32'h0800, 4'h3);
    wb(1'b1, 8'h24, {16'h0, c}, 4'h3);
    for (int i = 0; i < 2304; i++) begin @(posedge clk_i); cap[i] = line; end
  endtask
  task automatic vs_base(input logic [15:0] c, input int k);
    logic [2303:0] m;
    m = (2304'h1 << k) - 2304'h1;
    capture(c);
    check({31'h0, (cap & m) === (base & m)}, 32'h1);
    check({31'h0, cap !== base}, 32'h1);
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h18, 32'h0); rd(8'h1C, 32'h0); rd(8'h24, 32'h0); rd(8'h00, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 6; k++) begin
      lfsr = nxt(lfsr);
      d = ~lfsr;
      wb(1'b1, 8'h18, {16'h0, lfsr & POWER_TWO_MASK}, 4'h3);
      wb(1'b1, 8'h1C, {16'h0, d & DIGITAL_MASK}, 4'h3);
      rd(8'h18, {16'h0, lfsr & POWER_TWO_MASK});
      rd(8'h1C, {16'h0, d & DIGITAL_MASK});
      check({21'h0, pw}, {21'h0, lfsr[9], lfsr[3:0], d[7], d[6], d[4:3], d[1:0]});
      wb(1'b1, 8'h24, {16'h0, lfsr & TX_CTRL_MASK}, 4'h3);
      rd(8'h24, {16'h0, lfsr & TX_CTRL_MASK});
    end
    // lane 1 carries the inverted pll bit; with only lane 0 selected it must not land
    wb(1'b1, 8'h18, {22'h0, ~lfsr[9], 9'h00F}, 4'h1);
    rd(8'h18, {16'h0, (lfsr & 16'h0200) | 16'h000F});
    wb(1'b1, 8'h20, 32'hFFFF, 4'hF);
    rd(8'h20, 32'h0);
    $display("register test done");
    wb(1'b1, 8'h1C, 32'h0040, 4'h3);
    for (int c = 1; c < 8; c++) begin
      for (int v = 0; v < 2; v++) begin
        lfsr = nxt(lfsr);
        wb(1'b1, 8'h24, {16'h0, 1'b0, c[2:0], 2'b00, lfsr[1:0], lfsr[15:8]}, 4'h3);
        pin <= v ? (7'h01 << map[c]) : ~(7'h01 << map[c]);
        repeat (6) @(posedge clk_i);
        check({31'h0, line}, v);
      end
    end
    // clock enable low must freeze synchroniser and output register
    ce <= 1'b0;
    pin <= 7'h00;
    repeat (6) @(posedge clk_i);
    check({31'h0, line}, 32'h1);
    ce <= 1'b1;
    repeat (6) @(posedge clk_i);
    check({31'h0, line}, 32'h0);
    pin <= 7'h7F;
    wb(1'b1, 8'h24, 32'h3800, 4'h3);
    repeat (6) @(posedge clk_i);
    check({31'h0, line}, 32'h0);
    wb(1'b1, 8'h24, 32'h3000, 4'h3);
    wb(1'b1, 8'h1C, 32'h0000, 4'h3);
    repeat (6) @(posedge clk_i);
    check({31'h0, line}, 32'h0);
    $display("pass-through test done");
    pin <= 7'h00;
    wb(1'b1, 8'h1C, 32'h0040, 4'h3);
    e0 = edges;
    capture(16'h0000);
    base = cap;
    // every data slot opens with a transition, so one capture holds several hundred
    check({31'h0, (edges - e0) > 16'h0190}, 32'h1);
    vs_base(16'h0200, 100);
    vs_base(16'h0100, 500);
    vs_base(16'h0001, 2000);
    capture(16'h0400);
    check({31'h0, ((cap ^ ~base) >> 8) === 2304'h0}, 32'h1);
    $display("encoder test done");
    wb(1'b1, 8'h24, 32'h1000, 4'h3);
    n = 0;
    @(posedge clk_i);
    sv <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      if (sr === 1'b1) n++;
      lfsr = nxt(lfsr);
      sd <= {lfsr[7:0], lfsr};
    end
    sv <= 1'b0;
    check(n, FIFO_DEPTH);
    check({31'h0, sr}, 32'h0);
    wb(1'b1, 8'h24, 32'h0000, 4'h3);
    n = 0;
    while (sr !== 1'b1 && n < 400) begin @(posedge clk_i); n++; end
    check({31'h0, sr}, 32'h1);
    $display("buffer test done");
    wrap_up();
  end
endmodule // tb_power_and_spdif_tx_control
`default_nettype wire

// ### verilog/pstx_top.sv
// power control registers and s/pdif transmitter with pass-through source mux
`default_nettype none

module pstx_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR   = AW'(DEPTH - 1);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  assign in_ready_o  = (count_reg != FULL_COUNT);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // pstx_fifo

module pstx_top
  import pstx_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // classic wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  // power enables
  output logic                     pll_power_o,
  output logic                     headphone_dac_right_power_o,
  output logic                     headphone_dac_left_power_o,
  output logic                     headphone_amp_right_power_o,
  output logic                     headphone_amp_left_power_o,
  output logic                     pwm_power_o,
  output logic                     spdif_tx_power_o,
  output logic                     rate_converter_two_power_o,
  output logic                     rate_converter_one_power_o,
  output logic                     engine_power_o,
  output logic                     core_power_o,
  // internal audio stream, alternating first and second channel
  input  wire logic [SAMPLE_W-1:0] sample_data_i,
  input  wire logic                sample_valid_i,
  output logic                     sample_ready_o,
  // pass-through pins
  input  wire logic                passthru_input_0_i,
  input  wire logic                passthru_input_1_i,
  input  wire logic                passthru_input_2_i,
  input  wire logic                passthru_input_3_i,
  input  wire logic                passthru_input_4_i,
  input  wire logic                passthru_input_5_i,
  input  wire logic                passthru_input_6_i,
  output logic                     spdif_o
);
  localparam logic [7:0] POWER_TWO_ADR = {POWER_TWO_IDX[5:0], 2'b00};
  localparam logic [7:0] DIGITAL_ADR   = {DIGITAL_POWER_IDX[5:0], 2'b00};
  localparam logic [7:0] TX_CTRL_ADR   = {TX_CTRL_IDX[5:0], 2'b00};

  logic [15:0]         power_two_reg;
  logic [15:0]         digital_reg;
  logic [15:0]         tx_ctrl_reg;
  logic                ack_reg;
  logic [31:0]         rdata_reg;
  logic                bus_req;
  logic                bus_wr;
  logic [15:0]         rd_mux;
  logic [6:0]          pt_meta_reg;
  logic [6:0]          pt_sync_reg;
  logic                pt_sel;
  logic [2:0]          src;
  logic                tx_active;
  logic                enc_go;
  pstx_enc_state_t     state_reg;
  logic [7:0]          tick_cnt_reg;
  logic                tick;
  logic [5:0]          half_reg;
  logic [7:0]          frame_reg;
  logic                chan_b_reg;
  logic [SAMPLE_W-1:0] sample_reg;
  logic                line_reg;
  logic                out_reg;
  logic [SAMPLE_W-1:0] fifo_data;
  logic                fifo_valid;
  logic                fifo_pop;
  logic [31:0]         word;
  logic [7:0]          pre_pat;
  logic                cs_bit;
  logic [4:0]          slot;

  // byte lanes 0 and 1 carry the 16-bit registers; the upper lanes are ignored
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
    logic [15:0] val;
    val = old;
    if (wb_sel_i[0]) begin
      val[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      val[15:8] = wb_dat_i[15:8];
    end
    return val & mask;
  endfunction

  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_reg;
  assign bus_wr   = bus_req && wb_we_i;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= bus_req;
    end
  end

  // reserved bits are masked off, so a careless write cannot reach them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_two_reg <= POWER_TWO_RESET;
      digital_reg   <= DIGITAL_RESET;
      tx_ctrl_reg   <= TX_CTRL_RESET;
    end else if (ce_i && bus_wr) begin
      if (wb_adr_i == POWER_TWO_ADR) begin
        power_two_reg <= merge(power_two_reg, POWER_TWO_MASK);
      end
      if (wb_adr_i == DIGITAL_ADR) begin
        digital_reg <= merge(digital_reg, DIGITAL_MASK);
      end
      if (wb_adr_i == TX_CTRL_ADR) begin
        tx_ctrl_reg <= merge(tx_ctrl_reg, TX_CTRL_MASK);
      end
    end
  end

  always_comb begin
    case (wb_adr_i)
      POWER_TWO_ADR: rd_mux = power_two_reg;
      DIGITAL_ADR:   rd_mux = digital_reg;
      TX_CTRL_ADR:   rd_mux = tx_ctrl_reg;
      default:       rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i && bus_req) begin
      rdata_reg <= {16'h0000, rd_mux};
    end
  end

  assign pll_power_o                 = power_two_reg[PLL_BIT];
  assign headphone_dac_right_power_o = power_two_reg[HP_DAC_R_BIT];
  assign headphone_dac_left_power_o  = power_two_reg[HP_DAC_L_BIT];
  assign headphone_amp_right_power_o = power_two_reg[HP_AMP_R_BIT];
  assign headphone_amp_left_power_o  = power_two_reg[HP_AMP_L_BIT];
  assign pwm_power_o                 = digital_reg[PWM_BIT];
  assign spdif_tx_power_o            = digital_reg[TX_POWER_BIT];
  assign rate_converter_two_power_o  = digital_reg[RC_TWO_BIT];
  assign rate_converter_one_power_o  = digital_reg[RC_ONE_BIT];
  assign engine_power_o              = digital_reg[ENGINE_BIT];
  assign core_power_o                = digital_reg[CORE_BIT];

  // pass-through pins are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pt_meta_reg <= 7'h00;
      pt_sync_reg <= 7'h00;
    end else if (ce_i) begin
      pt_meta_reg <= {passthru_input_6_i, passthru_input_5_i, passthru_input_4_i,
                      passthru_input_3_i, passthru_input_2_i, passthru_input_1_i,
                      passthru_input_0_i};
      pt_sync_reg <= pt_meta_reg;
    end
  end

  assign src = tx_ctrl_reg[SRC_MSB:SRC_LSB];

  always_comb begin
    case (src)
      3'h1:    pt_sel = pt_sync_reg[2];
      3'h2:    pt_sel = pt_sync_reg[1];
      3'h3:    pt_sel = pt_sync_reg[0];
      3'h4:    pt_sel = pt_sync_reg[3];
      3'h5:    pt_sel = pt_sync_reg[4];
      3'h6:    pt_sel = pt_sync_reg[5];
      3'h7:    pt_sel = pt_sync_reg[6];
      default: pt_sel = 1'b0;
    endcase
  end

  // the transmitter needs both its power bit and a clear disable bit
  assign tx_active = spdif_tx_power_o && !tx_ctrl_reg[TX_DIS_BIT];
  assign enc_go    = tx_active && (src == SRC_INTERNAL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ENC_IDLE;
    end else if (ce_i) begin
      case (state_reg)
        ENC_IDLE: state_reg <= enc_go ? ENC_RUN : ENC_IDLE;
        ENC_RUN:  state_reg <= enc_go ? ENC_RUN : ENC_IDLE;
        default:  state_reg <= ENC_IDLE;
      endcase
    end
  end

  assign tick = (state_reg == ENC_RUN) && (tick_cnt_reg == HALF_CELL_CYCLES - 8'h01);

  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != ENC_RUN) begin
      tick_cnt_reg <= 8'h00;
    end else if (ce_i) begin
      tick_cnt_reg <= tick ? 8'h00 : tick_cnt_reg + 8'h01;
    end
  end

  // samples are drawn only at subframe boundaries, so the buffer fills and stalls the source
  pstx_fifo #(
    .W     (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_data_i   (sample_data_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  assign fifo_pop = tick && (half_reg == LAST_HALF);

  // channel status: copy flag and equipment byte sit in the first block bytes
  always_comb begin
    cs_bit = 1'b0;
    if (frame_reg == CS_COPY_FRAME) begin
      cs_bit = tx_ctrl_reg[COPY_BIT];
    end else if (frame_reg >= CS_EQUIP_FRAME && frame_reg < CS_EQUIP_FRAME + 8'h08) begin
      cs_bit = tx_ctrl_reg[frame_reg[2:0]];
    end
  end

  always_comb begin
    word = 32'h0000_0000;
    word[AUDIO_LSB_SLOT +: SAMPLE_W] = sample_reg;
    word[VALID_SLOT]  = tx_ctrl_reg[VALIDITY_BIT];
    word[USER_SLOT]   = 1'b0;
    word[STATUS_SLOT] = cs_bit;
    word[PARITY_SLOT] = ^word[STATUS_SLOT:AUDIO_LSB_SLOT];
  end

  always_comb begin
    if (chan_b_reg) begin
      pre_pat = PRE_SECOND;
    end else if (frame_reg == 8'h00) begin
      pre_pat = PRE_BLOCK;
    end else begin
      pre_pat = PRE_FIRST;
    end
  end

  assign slot = half_reg[5:1];

  // even parity returns the line to low before every preamble
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != ENC_RUN) begin
      half_reg   <= 6'h00;
      frame_reg  <= 8'h00;
      chan_b_reg <= 1'b0;
      line_reg   <= 1'b0;
      sample_reg <= '0;
    end else if (ce_i && tick) begin
      if (slot < FIRST_DATA_SLOT) begin
        line_reg <= pre_pat[3'h7 - half_reg[2:0]];
      end else if (!half_reg[0] || word[slot]) begin
        line_reg <= !line_reg;
      end
      half_reg <= half_reg + 6'h01;
      if (half_reg == LAST_HALF) begin
        // an empty buffer sends silence rather than stalling the link
        sample_reg <= fifo_valid ? fifo_data : '0;
        chan_b_reg <= !chan_b_reg;
        if (chan_b_reg) begin
          frame_reg <= (frame_reg == LAST_FRAME) ? 8'h00 : frame_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_reg <= 1'b0;
    end else if (ce_i) begin
      if (!tx_active) begin
        out_reg <= 1'b0;
      end else if (src == SRC_INTERNAL) begin
        out_reg <= line_reg ^ tx_ctrl_reg[PRE_EDGE_BIT];
      end else begin
        out_reg <= pt_sel;
      end
    end
  end

  assign spdif_o = out_reg;
endmodule // pstx_top
`default_nettype wire
